// ### dv/ims_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module ims_link_model
    import ims_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        txn_req,
    input  wire logic [3:0]  lat,
    input  wire ims_result_s want,
    output logic             txn_done,
    output ims_result_s      txn_result
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_r <= '0;
        else if (txn_req) cnt_r <= lat;
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
    assign txn_done = (cnt_r == 4'h1);
    // result is junk outside the done pulse
    assign txn_result = txn_done ? want : ~want;
endmodule : ims_link_model
`default_nettype wire

// ### dv/ims_sched_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ims_sched_properties
    import ims_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire ims_bus_req_s bus_req,
    input wire logic [31:0]  bus_rdata,
    input wire logic         uframe_start,
    input wire logic [2:0]   uframe_num,
    input wire logic         txn_req,
    input wire logic [2:0]   txn_uframe,
    input wire logic         txn_done,
    input wire ims_result_s  txn_result
);
    //==============================================================
    // transaction issue and read data
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence stall_s;
        txn_done && txn_result.stall;
    endsequence
    sequence busy_start_s;
        txn_req ##1 uframe_start;
    endsequence
    req_cause_a: assert property (txn_req |-> $past(uframe_start))
        else $error("request without start");
    req_pulse_a: assert property (txn_req |=> !txn_req)
        else $error("request too long");
    req_uframe_a: assert property (txn_req |-> txn_uframe == $past(uframe_num))
        else $error("wrong microframe");
    uframe_hold_a: assert property (!txn_req |-> $stable(txn_uframe))
        else $error("microframe moved");
    busy_refuse_a: assert property (busy_start_s |=> !txn_req)
        else $error("start taken while busy");
    halt_quiet_a: assert property (stall_s |=> !txn_req [*8])
        else $error("request after halt");
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
        else $error("read data outside slot");
endmodule : ims_sched_properties
bind ims_sched ims_sched_properties i_props (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .uframe_start(uframe_start), .uframe_num(uframe_num), .txn_req(txn_req),
    .txn_uframe(txn_uframe), .txn_done(txn_done), .txn_result(txn_result));
`default_nettype wire

// ### dv/iso_microframe_status_sched_test.sv
`timescale 1ns/100ps
`default_nettype none
module iso_microframe_status_sched_test;
    import ims_pkg::*;
    logic clk = 0, rst = 1, us = 0, req, irq, done;
    logic [2:0] un = 0, tu;
    logic [4:0] fr = 0;
    logic [1:0] tt;
    logic [3:0] lat = 4'h1;
    logic [31:0] rd;
    ims_bus_req_s b = '0;
    ims_result_s res = '0, tr;
    int num_errors = 0, checks_done = 0;
    always #50 clk = ~clk;
    ims_sched i_ims_sched (.clk(clk), .rst(rst), .bus_req(b), .bus_rdata(rd), .uframe_start(us),
        .uframe_num(un), .bus_frame_num(fr), .txn_req(req), .txn_token(tt), .txn_uframe(tu),
        .txn_done(done), .txn_result(tr), .irq(irq));
    ims_link_model i_ims_link_model (.clk(clk), .rst(rst), .txn_req(req), .lat(lat), .want(res),
        .txn_done(done), .txn_result(tr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        b <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        b <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        b <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        b <= '0;
        #1 chk(rd, e);
        @(posedge clk);
    endtask : rdc
    function automatic logic [31:0] fld(input logic [1:0] t, input ims_result_s s, input logic [2:0] u);
        return {29'h0, s.underrun & (t == TOKEN_OUT), s.babble & (t == TOKEN_IN), s.error} << (8 + 3 * u);
    endfunction : fld
    task automatic run(input logic [2:0] u, input logic [1:0] t, input logic miss, input ims_result_s s);
        logic [4:0] f;
        f = 5'($urandom);
        res <= s;
        lat <= 4'($urandom_range(1, 9));
        wr(REG_FRAME_CFG, {24'h0, f, 1'($urandom), t});
        wr(REG_CONTROL_WORD, 32'h8000_0000);
        wr(REG_STATUS_WORD, 32'h1 << u);
        us <= 1;
        un <= u;
        fr <= f ^ {4'h0, miss};
        @(posedge clk);
        us <= 0;
        #1 chk(req, !miss);
        if (!miss) chk({tt, tu}, {t, u});
        @(posedge clk);
        us <= 1;
        @(posedge clk);
        us <= 0;
        #1 chk(req, 0);
        repeat (10) @(posedge clk);
        rdc(REG_STATUS_WORD, miss ? 32'h1 << u : fld(t, s, u));
        rdc(REG_CONTROL_WORD, (s.stall && !miss) ? 32'h4000_0000 : 32'h8000_0000);
        chk(irq, !miss);
        wr(REG_IRQ_MASK, 32'h0);
        chk(irq, 0);
        wr(REG_IRQ_STATUS, 32'h7);
        wr(REG_IRQ_MASK, 32'h7);
        chk(irq, 0);
        $display("test done uframe %0d token %0d miss %0d", u, t, miss);
    endtask : run
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(19));
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rdc(REG_STATUS_WORD, STATUS_WORD_RST);
        rdc(4'hF, 32'h0);
        wr(REG_IRQ_MASK, 32'h7);
        run(3'h7, TOKEN_IN, 1'b0, ims_result_s'(4'hE));
        run(3'h0, TOKEN_OUT, 1'b0, ims_result_s'(4'hE));
        for (int n = 0; n < 40; n++) begin
            run(3'($urandom), 2'($urandom_range(0, 1)), $urandom_range(0, 3) == 0,
                ims_result_s'(4'($urandom)));
        end
        run(3'h3, TOKEN_IN, 1'b0, ims_result_s'(4'h1));
        wr(REG_STATUS_WORD, 32'hFF);
        us <= 1;
        @(posedge clk);
        us <= 0;
        #1 chk(req, 0);
        $display("test done halted descriptor");
        end_of_test();
    end
endmodule : iso_microframe_status_sched_test
`default_nettype wire

// ### logic/ims_pkg.sv
//======================================================================
// Behaviour
// - eight 3-bit results, uframe7 top, uframe0 low
// - result bit0 flags transaction error, IN/OUT
// - result bit1 flags babble, IN only
// - result bit2 flags underrun, OUT only
// - frame match: run only masked-active uframes, clear after
// - single halt flag; a stall sets it and clears valid
`default_nettype none
package ims_pkg;

    //==================================================================
    // descriptor field layout
    localparam int RES_W        = 3;
    localparam int NUM_UFRAMES  = 8;
    localparam int RES_LSB      = 8;
    localparam int RES_ERR_BIT  = 0;
    localparam int RES_BAB_BIT  = 1;
    localparam int RES_UND_BIT  = 2;
    localparam int FRAME_W      = 5;
    localparam int FRAME_LSB    = 3;
    localparam int ACTIVE_BIT   = 31;
    localparam int HALT_BIT     = 30;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN  = 2'h1;

    //==================================================================
    // register map
    localparam logic [3:0] REG_STATUS_WORD  = 4'h0;
    localparam logic [3:0] REG_CONTROL_WORD = 4'h1;
    localparam logic [3:0] REG_FRAME_CFG    = 4'h2;
    localparam logic [3:0] REG_IRQ_STATUS   = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK     = 4'h4;
    localparam logic [3:0] REG_SCHED_STATE  = 4'h5;

    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ERR_BIT   = 1;
    localparam int IRQ_HALT_BIT  = 2;
    localparam int IRQ_W         = 3;

    localparam logic [31:0] STATUS_WORD_RST  = 32'h0000_0000;
    localparam logic [31:0] CONTROL_WORD_RST = 32'h0000_0000;
    localparam logic [7:0]  FRAME_CFG_RST    = 8'h00;

    typedef enum logic [1:0] {
        SCHED_IDLE,
        SCHED_ISSUE,
        SCHED_WAIT
    } ims_state_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ims_bus_req_s;

    typedef struct packed {
        logic error;
        logic babble;
        logic underrun;
        logic stall;
    } ims_result_s;

endpackage : ims_pkg
`default_nettype wire

// ### logic/ims_sched.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ims_sched
    import ims_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire ims_bus_req_s  bus_req,
    output logic [31:0]        bus_rdata,
    input  wire logic          uframe_start,
    input  wire logic [2:0]    uframe_num,
    input  wire logic [4:0]    bus_frame_num,
    output logic               txn_req,
    output logic [1:0]         txn_token,
    output logic [2:0]         txn_uframe,
    input  wire logic          txn_done,
    input  wire ims_result_s   txn_result,
    output logic               irq
);

    //==================================================================
    // storage
    logic [31:0]            status_word_r;
    logic [31:0]            control_word_r;
    logic [7:0]             frame_cfg_r;
    logic [IRQ_W-1:0]       irq_status_r;
    logic [IRQ_W-1:0]       irq_mask_r;
    ims_state_e             state_r;
    logic [2:0]             cur_uf_r;
    logic [31:0]            rdata_nxt;

    logic        valid;
    logic [1:0]  token;
    logic        frame_match;
    logic [NUM_UFRAMES-1:0] uframe_active_mask;
    logic        sched_hit;
    logic        done_ev;
    logic [RES_W-1:0] result_nxt;
    logic [IRQ_W-1:0] irq_ev;

    assign valid       = control_word_r[ACTIVE_BIT];
    assign token       = frame_cfg_r[1:0];
    // low three bits of the frame config byte never take part in the frame match
    assign frame_match = (frame_cfg_r[7:FRAME_LSB] == bus_frame_num);
    // mask bits live in the low byte of the status word
    assign uframe_active_mask = status_word_r[NUM_UFRAMES-1:0];
    assign sched_hit   = uframe_start && valid && frame_match
                         && uframe_active_mask[uframe_num];
    assign done_ev     = (state_r == SCHED_WAIT) && txn_done;

    //==================================================================
    // result encoding
    always_comb begin
        result_nxt = '0;
        result_nxt[RES_ERR_BIT] = txn_result.error;
        if (token == TOKEN_IN) begin
            result_nxt[RES_BAB_BIT] = txn_result.babble;
        end
        if (token == TOKEN_OUT) begin
            result_nxt[RES_UND_BIT] = txn_result.underrun;
        end
    end

    //==================================================================
    // scheduler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r  <= SCHED_IDLE;
            cur_uf_r <= 3'h0;
        end else begin
            case (state_r)
                SCHED_IDLE: begin
                    if (sched_hit) begin
                        state_r  <= SCHED_ISSUE;
                        cur_uf_r <= uframe_num;
                    end
                end
                SCHED_ISSUE: begin
                    state_r <= SCHED_WAIT;
                end
                // starts arriving while busy are dropped, not queued
                SCHED_WAIT: begin
                    if (txn_done) begin
                        state_r <= SCHED_IDLE;
                    end
                end
                default: begin
                    state_r <= SCHED_IDLE;
                end
            endcase
        end
    end

    assign txn_req    = (state_r == SCHED_ISSUE);
    assign txn_token  = token;
    assign txn_uframe = cur_uf_r;

    //==================================================================
    // status word: hardware write-back wins over software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_word_r <= STATUS_WORD_RST;
        end else begin
            if (bus_req.wr && bus_req.addr == REG_STATUS_WORD) begin
                status_word_r <= bus_req.wdata;
            end
            if (done_ev) begin
                status_word_r[RES_LSB + RES_W*cur_uf_r +: RES_W] <= result_nxt;
                status_word_r[cur_uf_r] <= 1'b0;
            end
        end
    end

    //==================================================================
    // control word: active and halt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_word_r <= CONTROL_WORD_RST;
        end else begin
            if (bus_req.wr && bus_req.addr == REG_CONTROL_WORD) begin
                control_word_r <= bus_req.wdata;
            end
            // stall halts this descriptor until software sets the active bit again
            if (done_ev && txn_result.stall) begin
                control_word_r[HALT_BIT]   <= 1'b1;
                control_word_r[ACTIVE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_cfg_r <= FRAME_CFG_RST;
        end else if (bus_req.wr && bus_req.addr == REG_FRAME_CFG) begin
            frame_cfg_r <= bus_req.wdata[7:0];
        end
    end

    //==================================================================
    // interrupts: set beats write-one-to-clear
    assign irq_ev[IRQ_DONE_BIT] = done_ev;
    assign irq_ev[IRQ_ERR_BIT]  = done_ev && (result_nxt != '0);
    assign irq_ev[IRQ_HALT_BIT] = done_ev && txn_result.stall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status_r <= '0;
        end else begin
            if (bus_req.wr && bus_req.addr == REG_IRQ_STATUS) begin
                irq_status_r <= (irq_status_r & ~bus_req.wdata[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_status_r <= irq_status_r | irq_ev;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_r <= '0;
        end else if (bus_req.wr && bus_req.addr == REG_IRQ_MASK) begin
            irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    //==================================================================
    // read port
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (bus_req.addr == REG_STATUS_WORD) begin
            rdata_nxt = status_word_r;
        end else if (bus_req.addr == REG_CONTROL_WORD) begin
            rdata_nxt = control_word_r;
        end else if (bus_req.addr == REG_FRAME_CFG) begin
            rdata_nxt = {24'h000000, frame_cfg_r};
        end else if (bus_req.addr == REG_IRQ_STATUS) begin
            rdata_nxt = {29'h0, irq_status_r};
        end else if (bus_req.addr == REG_IRQ_MASK) begin
            rdata_nxt = {29'h0, irq_mask_r};
        end else if (bus_req.addr == REG_SCHED_STATE) begin
            rdata_nxt = {24'h000000, 3'h0, cur_uf_r, 2'(state_r)};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            bus_rdata <= rdata_nxt;
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

endmodule : ims_sched
`default_nettype wire
